// >>> rtl/asp_pkg.sv
// package: constants and types for the serial audio port pin block
package asp_pkg;
  // number of pins handled: rx clock, tx clock, data pin a, data pin b
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned PIN_RXCLK = 0;
  localparam int unsigned PIN_TXCLK = 1;
  localparam int unsigned PIN_DATA_A = 2;
  localparam int unsigned PIN_DATA_B = 3;
  // gpio direction codes per pin
  typedef enum logic [1:0] {
    ASP_GPIO_DISC = 2'b00,
    ASP_GPIO_IN   = 2'b01,
    ASP_GPIO_OUT  = 2'b10
  } asp_gpio_e;
  // data pin function select
  typedef enum logic [1:0] {
    ASP_DATA_OFF = 2'b00,
    ASP_DATA_TX  = 2'b01,
    ASP_DATA_RX  = 2'b10
  } asp_data_e;
  localparam logic [1:0] GPIO_DIR_RST = 2'b00;
  localparam logic       FLAG_RST     = 1'b0;
  localparam int unsigned SHIFT_W     = 24;
  localparam logic [23:0] SHIFT_RST   = 24'h000000;
endpackage : asp_pkg

// >>> rtl/asp_pins.sv
// module: pin-level muxing of the second serial audio port
//
// Functional notes
// - with sync mode off the rx bit clock pin is the receivers' clock.
// - with sync mode on the rx bit clock pin becomes serial flag zero.
// - as a flag its direction follows the rx clock direction bit.
// - an output flag drives the output flag zero bit onto the pin.
// - output flag updates reach the pin at frame sync or at each slot.
// - an input flag is captured into input flag zero at frame or slot.
// - with sync mode on the tx bit clock pin clocks tx and rx together.
// - with sync mode off the tx bit clock pin clocks transmitters only.
// - data pin a set for tx drives the tx shift register five bit.
// - data pin a set for rx feeds the rx shift register zero.
// - data pin b set for tx drives the tx shift register four bit.
// - data pin b set for rx feeds the rx shift register one.
// - in gpio mode each pin is input, output or disconnected.
// - after reset all pins are gpio disconnected.
`timescale 1ns/10ps
module asp_pins
  import asp_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   portEnable,
  input  wire logic                   syncModeSelect,
  input  wire logic                   rxClockDirectionBit,
  input  wire logic                   txClockDirectionBit,
  input  wire logic                   networkMode,
  input  wire logic                   frameSync,
  input  wire logic                   slotStart,
  input  wire logic                   outputFlagZero,
  input  wire logic                   rxClkGen,
  input  wire logic                   txClkGen,
  input  wire asp_pkg::asp_data_e     dataModeA,
  input  wire asp_pkg::asp_data_e     dataModeB,
  input  wire logic                   txShiftRegFiveBit,
  input  wire logic                   txShiftRegFourBit,
  input  wire logic [NUM_PINS*2-1:0]  gpioDir,
  input  wire logic [NUM_PINS-1:0]    gpioOut,
  input  wire logic [NUM_PINS-1:0]    pinIn,
  output logic      [NUM_PINS-1:0]    pinOut,
  output logic      [NUM_PINS-1:0]    pinOe,
  output logic      [NUM_PINS-1:0]    gpioIn,
  output logic                        inputFlagZero,
  output logic                        rxBitClock,
  output logic                        txBitClock,
  output logic                        rxClkEdge,
  output logic                        txClkEdge,
  output logic      [SHIFT_W-1:0]     rxShiftRegZero,
  output logic      [SHIFT_W-1:0]     rxShiftRegOne
);
  import asp_pkg::*;

  // ***************************************
  // pin synchronisers
  // ***************************************
  logic [NUM_PINS-1:0] pinMeta_r;
  logic [NUM_PINS-1:0] pinSync_r;
  logic [NUM_PINS-1:0] pinPrev_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      pinPrev_r <= '0;
    end else begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  // generated clocks are levels too; a high level is not an edge
  logic rxGenPrev_r;
  logic txGenPrev_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxGenPrev_r <= 1'b0;
      txGenPrev_r <= 1'b0;
    end else begin
      rxGenPrev_r <= rxClkGen;
      txGenPrev_r <= txClkGen;
    end
  end

  // ***************************************
  // pin roles
  // ***************************************
  logic rxClkIsFlag;
  logic flagIsOut;
  logic slotTick;
  logic rxPinClk;
  logic txPinClk;
  logic rxRise;
  logic txRise;
  logic rxGenRise;
  logic txGenRise;

  assign rxClkIsFlag = portEnable && syncModeSelect;
  assign flagIsOut   = rxClockDirectionBit;
  // network mode updates per slot, normal mode per frame
  assign slotTick    = networkMode ? slotStart : frameSync;
  assign rxPinClk    = rxClockDirectionBit ? rxClkGen : pinSync_r[PIN_RXCLK];
  assign txPinClk    = txClockDirectionBit ? txClkGen : pinSync_r[PIN_TXCLK];

  // receivers follow tx clock in sync mode, rx pin otherwise
  assign rxBitClock = !portEnable ? 1'b0 :
                      syncModeSelect ? txPinClk : rxPinClk;
  assign txBitClock = portEnable ? txPinClk : 1'b0;

  // generated clock rises show at once; pin clock rises lag two flops
  assign rxGenRise = rxClkGen && !rxGenPrev_r;
  assign txGenRise = txClkGen && !txGenPrev_r;
  assign rxRise = syncModeSelect
    ? (txClockDirectionBit ? txGenRise
       : pinSync_r[PIN_TXCLK] && !pinPrev_r[PIN_TXCLK])
    : (rxClockDirectionBit ? rxGenRise
       : pinSync_r[PIN_RXCLK] && !pinPrev_r[PIN_RXCLK]);
  assign txRise = txClockDirectionBit ? txGenRise
                : pinSync_r[PIN_TXCLK] && !pinPrev_r[PIN_TXCLK];
  assign rxClkEdge = portEnable && rxRise;
  assign txClkEdge = portEnable && txRise;

  // ***************************************
  // serial flag zero
  // ***************************************
  logic flagOut_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flagOut_r <= FLAG_RST;
    end else if (rxClkIsFlag && flagIsOut && slotTick) begin
      flagOut_r <= outputFlagZero;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inputFlagZero <= FLAG_RST;
    end else if (rxClkIsFlag && !flagIsOut && slotTick) begin
      inputFlagZero <= pinSync_r[PIN_RXCLK];
    end
  end

  // code 11 falls through to off in both decoders
  function automatic logic dataIsRx(input asp_data_e mode);
    dataIsRx = (mode == ASP_DATA_RX);
  endfunction : dataIsRx

  function automatic logic dataIsTx(input asp_data_e mode);
    dataIsTx = (mode == ASP_DATA_TX);
  endfunction : dataIsTx

  // ***************************************
  // receive shift registers
  // ***************************************
  // bits shift on the rx clock rising edge; word framing lives elsewhere
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxShiftRegZero <= SHIFT_RST;
    end else if (portEnable && dataIsRx(dataModeA) && rxClkEdge) begin
      rxShiftRegZero <= {rxShiftRegZero[SHIFT_W-2:0],
                         pinSync_r[PIN_DATA_A]};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxShiftRegOne <= SHIFT_RST;
    end else if (portEnable && dataIsRx(dataModeB) && rxClkEdge) begin
      rxShiftRegOne <= {rxShiftRegOne[SHIFT_W-2:0],
                        pinSync_r[PIN_DATA_B]};
    end
  end

  // ***************************************
  // pad drivers
  // ***************************************
  function automatic logic gpioOutEn(input logic [1:0] dir);
    gpioOutEn = (dir == ASP_GPIO_OUT);
  endfunction : gpioOutEn

  function automatic logic gpioInEn(input logic [1:0] dir);
    gpioInEn = (dir == ASP_GPIO_IN);
  endfunction : gpioInEn

  logic [NUM_PINS-1:0] funcOe;
  logic [NUM_PINS-1:0] funcOut;

  always_comb begin
    funcOe  = '0;
    funcOut = '0;
    if (syncModeSelect) begin
      funcOe[PIN_RXCLK]  = flagIsOut;
      funcOut[PIN_RXCLK] = flagOut_r;
    end else begin
      funcOe[PIN_RXCLK]  = rxClockDirectionBit;
      funcOut[PIN_RXCLK] = rxClkGen;
    end
    funcOe[PIN_TXCLK]   = txClockDirectionBit;
    funcOut[PIN_TXCLK]  = txClkGen;
    funcOe[PIN_DATA_A]  = dataIsTx(dataModeA);
    funcOut[PIN_DATA_A] = txShiftRegFiveBit;
    funcOe[PIN_DATA_B]  = dataIsTx(dataModeB);
    funcOut[PIN_DATA_B] = txShiftRegFourBit;
  end

  // outputs registered; gpio disconnected drives and samples nothing
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pad
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pinOe[gi]  <= 1'b0;
          pinOut[gi] <= 1'b0;
          gpioIn[gi] <= 1'b0;
        end else if (portEnable) begin
          pinOe[gi]  <= funcOe[gi];
          pinOut[gi] <= funcOut[gi];
          gpioIn[gi] <= 1'b0;
        end else begin
          pinOe[gi]  <= gpioOutEn(gpioDir[gi*2 +: 2]);
          pinOut[gi] <= gpioOut[gi];
          gpioIn[gi] <= gpioInEn(gpioDir[gi*2 +: 2]) & pinSync_r[gi];
        end
      end
    end
  endgenerate
endmodule : asp_pins

// >>> dv/asp_pins_sva.sv
// checker: pin muxing assertions for the serial audio port
`timescale 1ns/10ps
module asp_pins_sva
  import asp_pkg::*;
(
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic               portEnable,
  input wire logic               syncModeSelect,
  input wire logic               rxClockDirectionBit,
  input wire logic               networkMode,
  input wire logic               frameSync,
  input wire logic               outputFlagZero,
  input wire logic               txShiftRegFiveBit,
  input wire logic               txShiftRegFourBit,
  input wire logic               inputFlagZero,
  input wire logic               rxClkEdge,
  input wire asp_pkg::asp_data_e dataModeA,
  input wire asp_pkg::asp_data_e dataModeB,
  input wire logic [7:0]         gpioDir,
  input wire logic [3:0]         gpioOut,
  input wire logic [3:0]         pinIn,
  input wire logic [3:0]         pinOut,
  input wire logic [3:0]         pinOe,
  input wire logic [23:0]        rxShiftRegZero
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic en = portEnable;
  wire logic flg = en && syncModeSelect && !networkMode && frameSync;
  property p_off; !en && gpioDir == 8'h00 |=> pinOe == 4'h0; endproperty
  a_off: assert property (p_off) else $error("pins driven");
  property p_gout; !en && gpioDir[1:0] == ASP_GPIO_OUT
    |=> pinOe[0] && pinOut[0] == $past(gpioOut[0]); endproperty
  a_gout: assert property (p_gout) else $error("gpio out");
  property p_tx5; en && dataModeA == ASP_DATA_TX
    |=> pinOe[2] && pinOut[2] == $past(txShiftRegFiveBit); endproperty
  a_tx5: assert property (p_tx5) else $error("tx five");
  property p_tx4; en && dataModeB == ASP_DATA_TX
    |=> pinOe[3] && pinOut[3] == $past(txShiftRegFourBit); endproperty
  a_tx4: assert property (p_tx4) else $error("tx four");
  property p_nodrv; en && dataModeB == ASP_DATA_RX |=> !pinOe[3]; endproperty
  a_nodrv: assert property (p_nodrv) else $error("rx pin driven");
  property p_hold; !(en && dataModeA == ASP_DATA_RX)
    |=> $stable(rxShiftRegZero); endproperty
  a_hold: assert property (p_hold) else $error("rx shifted");
  property p_shift; en && dataModeA == ASP_DATA_RX && rxClkEdge
    |=> rxShiftRegZero[23:1] == $past(rxShiftRegZero[22:0]); endproperty
  a_shift: assert property (p_shift) else $error("rx shift");
  property p_clkin; en && !syncModeSelect && !rxClockDirectionBit
    |=> !pinOe[0]; endproperty
  a_clkin: assert property (p_clkin) else $error("clock pin driven");
  property p_oflag; flg && rxClockDirectionBit
    |=> ##1 pinOe[0] && pinOut[0] == $past(outputFlagZero, 2); endproperty
  a_oflag: assert property (p_oflag) else $error("out flag");
  property p_iflag; flg && !rxClockDirectionBit
    |=> inputFlagZero == $past(pinIn[0], 3); endproperty
  a_iflag: assert property (p_iflag) else $error("in flag");
  c_flag: cover property (flg);
  c_shift: cover property (en && rxClkEdge);
  c_gpio: cover property (!en && pinOe != 4'h0);
endmodule : asp_pins_sva
bind asp_pins asp_pins_sva u_sva (.*);

// >>> dv/asp_codec.sv
// partner: codec model on the far side of the port pins
`timescale 1ns/10ps
module asp_codec (
  input  wire logic [1:0] run,
  input  wire logic       flagLvl,
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOe,
  output logic      [3:0] pinIn
);
  logic        linkClk = 1'b0;
  logic [23:0] word_r  = 24'ha5c3f0;
  // link clock stands still between frames
  always #80 if (run != 2'b00) linkClk = ~linkClk;
  // data moves on the fall so it is settled at the rise
  always @(negedge linkClk) word_r <= {word_r[22:0], word_r[23]};
  // pad level: the port wins while it drives
  assign pinIn[0] = pinOe[0] ? pinOut[0] : (run[0] ? linkClk : flagLvl);
  assign pinIn[1] = pinOe[1] ? pinOut[1] : (run[1] & linkClk);
  assign pinIn[2] = pinOe[2] ? pinOut[2] : word_r[23];
  assign pinIn[3] = pinOe[3] ? pinOut[3] : word_r[23];
endmodule : asp_codec

// >>> dv/asp_pins_tb.sv
// testbench: directed tests of the serial audio port pin block
`timescale 1ns/10ps
module asp_pins_tb;
  import asp_pkg::*;
  logic clk = 0, rstn = 0, en = 0, sync = 0, rxDir = 0, net = 0, fs = 0;
  logic ss = 0, of0 = 0, tx5 = 0, tx4 = 0, flagLvl = 0, iflag;
  logic txDir = 0, genClk = 0, rxBit, txBit, rxEdge, txEdge;
  logic [1:0] run = 2'b00;
  asp_data_e modeA = ASP_DATA_OFF, modeB = ASP_DATA_OFF;
  logic [7:0] gpioDir = 8'h00;
  logic [3:0] gpioOut = 4'h0, pinIn, pinOut, pinOe, gpioIn;
  logic [23:0] rx0, rx1;
  int miscompares = 0, checks_done = 0;
  asp_pins dut (.clk(clk), .rstn(rstn), .portEnable(en),
    .syncModeSelect(sync), .rxClockDirectionBit(rxDir),
    .txClockDirectionBit(txDir), .networkMode(net), .frameSync(fs),
    .slotStart(ss), .outputFlagZero(of0), .rxClkGen(genClk),
    .txClkGen(genClk), .dataModeA(modeA), .dataModeB(modeB),
    .txShiftRegFiveBit(tx5), .txShiftRegFourBit(tx4), .gpioDir(gpioDir),
    .gpioOut(gpioOut), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .gpioIn(gpioIn), .inputFlagZero(iflag), .rxBitClock(rxBit),
    .txBitClock(txBit), .rxClkEdge(rxEdge), .txClkEdge(txEdge),
    .rxShiftRegZero(rx0), .rxShiftRegOne(rx1));
  asp_codec u_codec (.run(run), .flagLvl(flagLvl), .pinOut(pinOut),
    .pinOe(pinOe), .pinIn(pinIn));
  initial forever #5 clk = ~clk;
  task automatic chk(input string n, input logic [23:0] e, s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n); repeat (n) @(negedge clk); endtask : cyc
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // hang guard, far beyond the longest test
  initial begin #500000; miscompares++; conclude(); end
  initial begin
    cyc(6); rstn = 1; cyc(2);
    chk("pinOe", 0, pinOe);
    chk("gpioIn", 0, gpioIn);
    chk("rx0", 0, rx0);
    $display("test reset done");
    gpioDir = 8'h62; gpioOut = 4'h5; cyc(5);
    chk("pinOe", 4'h5, pinOe);
    chk("pinOut", 4'h5, pinOut & 4'h5);
    chk("gpioIn", 4'h8, gpioIn);
    $display("test gpio done");
    gpioDir = 8'h00; en = 1; modeA = ASP_DATA_TX; modeB = ASP_DATA_TX;
    tx5 = 1; cyc(2);
    chk("pinOe", 4'hc, pinOe);
    chk("pinOut", 4'h4, pinOut & 4'hc);
    // code 11 must leave pin a undriven, like off
    modeA = asp_data_e'(2'b11); modeB = ASP_DATA_RX; cyc(2);
    chk("pinOe", 0, pinOe);
    modeA = ASP_DATA_RX;
    $display("test tx done");
    // async clocks rx from pin 0, sync from pin 1 only; a short second
    // word leaves a rotated pattern, so a wrong clock pin shows up
    for (int m = 0; m < 2; m++) begin
      sync = m[0]; run = m[0] ? 2'b10 : 2'b01;
      repeat (m ? 12 : 24) @(posedge u_codec.linkClk);
      @(negedge u_codec.linkClk) run = 2'b00;
      cyc(6);
      chk("rx0", m ? 24'h3f0a5c : 24'ha5c3f0, rx0);
      chk("rx1", m ? 24'h3f0a5c : 24'ha5c3f0, rx1);
    end
    $display("test rx done");
    rxDir = 1; of0 = 1; cyc(3);
    chk("flagOe", 1, pinOe[0]);
    chk("oflag", 0, pinOut[0]);
    fs = 1; cyc(1); fs = 0; cyc(2);
    chk("oflag", 1, pinOut[0]);
    net = 1; of0 = 0; ss = 1; cyc(1); ss = 0; cyc(2);
    chk("oflag", 0, pinOut[0]);
    rxDir = 0; net = 0; flagLvl = 1; cyc(4);
    chk("iflag", 0, iflag);
    fs = 1; cyc(1); fs = 0; cyc(2);
    chk("iflag", 1, iflag);
    $display("test flags done");
    // generated tx clock feeds its pin and, in sync mode, the receivers
    txDir = 1; genClk = 1; #1;
    chk("edges", 2'b11, {rxEdge, txEdge});
    chk("clocks", 2'b11, {rxBit, txBit});
    cyc(1);
    chk("edges", 0, {rxEdge, txEdge});
    chk("txPin", 2'b11, {pinOe[1], pinOut[1]});
    cyc(2);
    chk("rx0", 24'h7e14b8, rx0);
    $display("test gen clock done");
    conclude();
  end
endmodule : asp_pins_tb
